// >>> exs_defs.svh
// Constants of the exception sequencer: offsets, field positions, vectors, resets
`ifndef EXS_DEFS_SVH
`define EXS_DEFS_SVH
`define EXS_ADDR_W 4
`define EXS_OFF_MSR 4'h0
`define EXS_OFF_SAVE_RESTORE_PC 4'h4
`define EXS_OFF_SAVE_RESTORE_STATUS 4'h8
`define EXS_OFF_STAT 4'hC
`define EXS_MSR_EE 15
`define EXS_MSR_PR 14
`define EXS_MSR_RI 1
`define EXS_MSR_RST 32'h0000_0000
`define EXS_SAVE_RESTORE_STATUS_CAUSE_LSB 27
`define EXS_SAVE_RESTORE_STATUS_KEEP 27
`define EXS_VEC_SHIFT 8
`define EXS_VEC_RESET 5'h01
`define EXS_VEC_MCHECK 5'h02
`define EXS_VEC_EXT 5'h05
`define EXS_VEC_DEC 5'h09
`define EXS_VEC_SMI 5'h14
`define EXS_VEC_BASE_RST 32'h0000_0000
`define EXS_NUM_CAUSES 8
`define EXS_CAUSE_SYSCALL 5
`define EXS_PIN_W 6
`define EXS_PIN_SRST 0
`define EXS_PIN_HRST 1
`define EXS_PIN_TEA 2
`define EXS_PIN_MCP 3
`define EXS_PIN_INT 4
`define EXS_PIN_SMI 5
`endif

// >>> exs_pkg.sv
// Types shared by the exception sequencer modules
`include "exs_defs.svh"
package exs_pkg;
    typedef enum logic [2:0] {
        EXS_IDLE    = 3'b001,
        EXS_WAIT    = 3'b010,
        EXS_HANDLER = 3'b100
    } exs_state_e;

    typedef struct packed {
        logic [`EXS_PIN_W-1:0] f1;
        logic [`EXS_PIN_W-1:0] f2;
        logic [`EXS_PIN_W-1:0] f3;
        logic [`EXS_PIN_W-1:0] lvl;
    } exs_sync_s;

    typedef struct packed {
        exs_state_e                 state;
        logic [31:0]                machine_state_reg;
        logic [31:0]                save_restore_pc;
        logic [31:0]                save_restore_status;
        logic [31:0]                faultPc;
        logic [31:0]                nextPc;
        logic                       trapFlag;
        logic [`EXS_NUM_CAUSES-1:0] excBits;
        logic                       asyncRec;
        logic [4:0]                 asyncIdx;
        logic                       mcPend;
        logic                       rstPrev;
        logic                       redirect;
        logic [31:0]                vecAddr;
        logic                       holdCmpl;
        logic [31:0]                rdData;
    } exs_core_s;
endpackage

// >>> exs_pin_if.sv
// Carrier of the filtered pin levels between synchroniser and sequencer
`timescale 1ns/1ps
`include "exs_defs.svh"
interface exs_pin_if;
    logic [`EXS_PIN_W-1:0] lvl;
    modport drv (output lvl);
    modport rcv (input lvl);
endinterface

// >>> exs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "exs_defs.svh"
module exs_pin_sync #(
    parameter int W = `EXS_PIN_W
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pinsIn,
    exs_pin_if.drv            pins
);
    exs_pkg::exs_sync_s syncReg;
    exs_pkg::exs_sync_s syncNext;

    if (W != `EXS_PIN_W) begin : g_bad_width
        $error("exs_pin_sync: W must match the pin carrier width");
    end

    always_comb begin
        syncNext = syncReg;
        syncNext.f1 = pinsIn;
        syncNext.f2 = syncReg.f1;
        syncNext.f3 = syncReg.f2;
        // Only agreeing bits move, so a single-cycle glitch never counts
        syncNext.lvl = (syncReg.f2 & syncReg.f3) | (syncReg.lvl & (syncReg.f2 | syncReg.f3));
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncReg <= '0;
        end else begin
            syncReg <= syncNext;
        end
    end

    assign pins.lvl = syncReg.lvl;
endmodule

// >>> exs_sequencer.sv
// Exception recognition and sequencing: classify, order, drain and vector
`timescale 1ns/1ps
`include "exs_defs.svh"
module exs_sequencer #(
    parameter logic [31:0] VECTOR_BASE = `EXS_VEC_BASE_RST
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       softResetIn,
    input  wire logic                       hardResetIn,
    input  wire logic                       transferErrorAck,
    input  wire logic                       machineCheckIn,
    input  wire logic                       extIrqIn,
    input  wire logic                       sysMgmtIrq,
    input  wire logic                       decrementerIrq,
    input  wire logic                       dataBusActive,
    input  wire logic                       addrParityErr,
    input  wire logic                       dataParityErr,
    input  wire logic                       cmplValid,
    input  wire logic                       cmplDone,
    input  wire logic                       cmplExc,
    input  wire logic [`EXS_NUM_CAUSES-1:0] cmplExcBits,
    input  wire logic                       cmplIsTrap,
    input  wire logic [31:0]                cmplPc,
    input  wire logic [31:0]                cmplNextPc,
    input  wire logic                       olderBusy,
    input  wire logic                       execEmpty,
    input  wire logic [31:0]                idleRestartPc,
    input  wire logic                       storeQueueEmpty,
    input  wire logic                       rfiExec,
    input  wire logic [`EXS_ADDR_W-1:0]     regAddr,
    input  wire logic [31:0]                regWrData,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic [31:0]                     regRdData,
    output logic                            fetchRedirect,
    output logic [31:0]                     fetchVector,
    output logic                            holdCompletion,
    output logic                            problemState,
    output logic                            extIrqEnable
);
    exs_pkg::exs_core_s r_reg;
    exs_pkg::exs_core_s r_next;
    exs_pin_if pinBus ();
    logic rstEdge;
    logic mcEvent;

    if (VECTOR_BASE[19:0] != 20'h0_0000) begin : g_bad_base
        $error("exs_sequencer: vector base not aligned");
    end

    exs_pin_sync #(.W(`EXS_PIN_W)) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pinsIn  ({sysMgmtIrq, extIrqIn, machineCheckIn, transferErrorAck,
                   hardResetIn, softResetIn}),
        .pins    (pinBus)
    );

    function automatic logic [31:0] vecOf(input logic [4:0] idx);
        vecOf = VECTOR_BASE | {19'h0_0000, idx, 8'h00};
    endfunction

    // Cause bit to vector index: DSI, ISI, align, program, fp, syscall, trace, fp assist
    function automatic logic [4:0] causeIdx(input logic [2:0] bitNo);
        unique case (bitNo)
            3'h0: causeIdx = 5'h03;
            3'h1: causeIdx = 5'h04;
            3'h2: causeIdx = 5'h06;
            3'h3: causeIdx = 5'h07;
            3'h4: causeIdx = 5'h08;
            3'h5: causeIdx = 5'h0C;
            3'h6: causeIdx = 5'h0D;
            3'h7: causeIdx = 5'h0E;
        endcase
    endfunction

    function automatic logic [2:0] lowestBit(input logic [`EXS_NUM_CAUSES-1:0] bits);
        lowestBit = 3'h0;
        for (int i = `EXS_NUM_CAUSES - 1; i >= 0; i--) begin
            if (bits[i]) lowestBit = 3'(i);
        end
    endfunction

    // Edge, not level: a reset pin held high vectors only once
    assign rstEdge = (pinBus.lvl[`EXS_PIN_SRST] | pinBus.lvl[`EXS_PIN_HRST]) & ~r_reg.rstPrev;
    // Bus error only counts while a data beat is on the bus
    assign mcEvent = (pinBus.lvl[`EXS_PIN_TEA] & dataBusActive) | pinBus.lvl[`EXS_PIN_MCP]
                   | addrParityErr | dataParityErr;

    always_comb begin
        logic        take;
        logic        precise;
        logic [4:0]  takeIdx;
        logic [31:0] takePc;
        logic [2:0]  lb;
        take = 1'b0;
        precise = 1'b1;
        takeIdx = 5'h00;
        takePc = 32'h0000_0000;
        lb = lowestBit(r_reg.excBits);
        r_next = r_reg;
        r_next.redirect = 1'b0;
        r_next.rdData = 32'h0000_0000;
        r_next.rstPrev = pinBus.lvl[`EXS_PIN_SRST] | pinBus.lvl[`EXS_PIN_HRST];
        if (regWr) begin
            unique case (regAddr)
                `EXS_OFF_MSR:  r_next.machine_state_reg = regWrData;
                `EXS_OFF_SAVE_RESTORE_PC: r_next.save_restore_pc = regWrData;
                `EXS_OFF_SAVE_RESTORE_STATUS: r_next.save_restore_status = regWrData;
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                `EXS_OFF_MSR:  r_next.rdData = r_reg.machine_state_reg;
                `EXS_OFF_SAVE_RESTORE_PC: r_next.rdData = r_reg.save_restore_pc;
                `EXS_OFF_SAVE_RESTORE_STATUS: r_next.rdData = r_reg.save_restore_status;
                `EXS_OFF_STAT: r_next.rdData = {14'h0000, 3'(r_reg.state), r_reg.asyncIdx,
                                               r_reg.asyncRec, r_reg.mcPend, r_reg.excBits};
                default:       r_next.rdData = 32'h0000_0000;
            endcase
        end
        // A check pin held high re-arms the check every cycle until it drops
        if (mcEvent) r_next.mcPend = 1'b1;
        // Maskable sources are level requests gated by the enable bit
        r_next.asyncRec = r_reg.machine_state_reg[`EXS_MSR_EE] & (pinBus.lvl[`EXS_PIN_INT] | decrementerIrq
                          | pinBus.lvl[`EXS_PIN_SMI]);
        r_next.asyncIdx = pinBus.lvl[`EXS_PIN_INT] ? `EXS_VEC_EXT :
                          decrementerIrq ? `EXS_VEC_DEC : `EXS_VEC_SMI;
        unique case (r_reg.state)
            exs_pkg::EXS_IDLE: begin
                // Floating-point causes arrive as ordinary precise causes whatever the mode
                if (cmplValid && cmplExc) begin
                    r_next.excBits = cmplExcBits;
                    r_next.faultPc = cmplPc;
                    r_next.nextPc = cmplNextPc;
                    r_next.trapFlag = cmplIsTrap;
                    r_next.holdCmpl = 1'b1;
                    r_next.state = exs_pkg::EXS_WAIT;
                end else if (r_reg.asyncRec && storeQueueEmpty
                             && (cmplDone || execEmpty)) begin
                    take = 1'b1;
                    takeIdx = r_reg.asyncIdx;
                    takePc = cmplDone ? cmplNextPc : idleRestartPc;
                end
            end
            exs_pkg::EXS_WAIT: begin
                if (!olderBusy && storeQueueEmpty) begin
                    take = 1'b1;
                    takeIdx = causeIdx(lb);
                    takePc = (r_reg.trapFlag || lb == 3'(`EXS_CAUSE_SYSCALL))
                             ? r_reg.nextPc : r_reg.faultPc;
                    r_next.excBits[lb] = 1'b0;
                    r_next.holdCmpl = 1'b0;
                end
            end
            exs_pkg::EXS_HANDLER: begin
                if (rfiExec) begin
                    r_next.machine_state_reg = {5'h00, r_reg.save_restore_status[`EXS_SAVE_RESTORE_STATUS_KEEP-1:0]};
                    if (r_reg.excBits != '0) begin
                        r_next.state = exs_pkg::EXS_WAIT;
                        r_next.holdCmpl = 1'b1;
                    end else begin
                        r_next.state = exs_pkg::EXS_IDLE;
                    end
                end
            end
        endcase
        if (r_reg.mcPend) begin
            take = 1'b1;
            precise = 1'b0;
            takeIdx = `EXS_VEC_MCHECK;
            takePc = cmplPc;
            r_next.mcPend = mcEvent;
            r_next.excBits = '0;
            r_next.holdCmpl = 1'b0;
        end
        if (rstEdge) begin
            take = 1'b1;
            precise = 1'b0;
            takeIdx = `EXS_VEC_RESET;
            takePc = cmplPc;
            r_next.mcPend = 1'b0;
            r_next.asyncRec = 1'b0;
            r_next.excBits = '0;
            r_next.holdCmpl = 1'b0;
        end
        // Hardware save wins over a software write in the same cycle
        if (take) begin
            r_next.save_restore_pc = takePc;
            r_next.save_restore_status = {takeIdx, r_reg.machine_state_reg[`EXS_SAVE_RESTORE_STATUS_KEEP-1:0]};
            r_next.machine_state_reg[`EXS_MSR_EE] = 1'b0;
            r_next.machine_state_reg[`EXS_MSR_PR] = 1'b0;
            r_next.machine_state_reg[`EXS_MSR_RI] = precise;
            r_next.redirect = 1'b1;
            r_next.vecAddr = vecOf(takeIdx);
            r_next.state = exs_pkg::EXS_HANDLER;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '{state: exs_pkg::EXS_IDLE, machine_state_reg: `EXS_MSR_RST, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign regRdData = r_reg.rdData;
    assign fetchRedirect = r_reg.redirect;
    assign fetchVector = r_reg.vecAddr;
    assign holdCompletion = r_reg.holdCmpl;
    assign problemState = r_reg.machine_state_reg[`EXS_MSR_PR];
    assign extIrqEnable = r_reg.machine_state_reg[`EXS_MSR_EE];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_take_super: assert property (
        r_reg.redirect |-> !problemState && !extIrqEnable && r_reg.state == exs_pkg::EXS_HANDLER)
        else $error("taken exception not in supervisor handler state");
    a_reset_vec: assert property (
        rstEdge |=> fetchRedirect && fetchVector == (VECTOR_BASE | 32'h0000_0100))
        else $error("reset did not vector to 00100");
    a_reset_first: assert property (
        rstEdge && r_reg.mcPend |=> !r_reg.mcPend ##1 !fetchRedirect || rstEdge)
        else $error("machine check survived a reset");
    a_mcheck_vec: assert property (
        r_reg.mcPend && !rstEdge |=> fetchVector == (VECTOR_BASE | 32'h0000_0200))
        else $error("machine check did not vector to 00200");
    a_wait_hold: assert property (
        r_reg.state == exs_pkg::EXS_WAIT |-> holdCompletion)
        else $error("completion not held while fault pending");
    a_older_first: assert property (
        r_reg.state == exs_pkg::EXS_WAIT && olderBusy && !r_reg.mcPend && !rstEdge
        |=> !fetchRedirect)
        else $error("exception taken before older instructions");
    a_ext_gated: assert property (
        fetchRedirect && fetchVector == (VECTOR_BASE | 32'h0000_0500)
        |-> $past(r_reg.asyncRec) && $past(storeQueueEmpty))
        else $error("external interrupt taken while masked or undrained");
    a_one_at_time: assert property (
        r_reg.state == exs_pkg::EXS_HANDLER && !r_reg.mcPend && !rstEdge |=> !fetchRedirect)
        else $error("second exception taken inside handler");
    a_one_cause: assert property (
        r_reg.state == exs_pkg::EXS_WAIT && !olderBusy && storeQueueEmpty
        && !r_reg.mcPend && !rstEdge
        |=> $countones(r_reg.excBits) == $countones($past(r_reg.excBits)) - 1)
        else $error("causes of one instruction not taken singly");
    a_recov_saved: assert property (
        fetchRedirect |-> r_reg.save_restore_status[`EXS_MSR_RI] == $past(r_reg.machine_state_reg[`EXS_MSR_RI]))
        else $error("recoverable flag not saved");

    // Drain, masking, precision and saved-address guards
    a_mc_imprecise: assert property (
        r_reg.mcPend && !rstEdge |=> !r_reg.machine_state_reg[`EXS_MSR_RI])
        else $error("machine check marked recoverable");
    a_reset_imprecise: assert property (
        rstEdge |=> !r_reg.machine_state_reg[`EXS_MSR_RI] && r_reg.state == exs_pkg::EXS_HANDLER)
        else $error("system reset marked recoverable");
    a_async_drain: assert property (
        r_reg.state == exs_pkg::EXS_IDLE && !storeQueueEmpty && !r_reg.mcPend && !rstEdge
        |=> !fetchRedirect)
        else $error("interrupt taken before store queue drained");
    a_defer_mask: assert property (
        r_reg.state == exs_pkg::EXS_IDLE && !cmplDone && !execEmpty && !r_reg.mcPend
        && !rstEdge |=> !fetchRedirect)
        else $error("interrupt taken before next instruction completed");
    a_ext_masked: assert property (
        !extIrqEnable |=> !r_reg.asyncRec)
        else $error("maskable request recorded while disabled");
    a_async_restart: assert property (
        r_reg.state == exs_pkg::EXS_IDLE && !(cmplValid && cmplExc) && r_reg.asyncRec
        && storeQueueEmpty && execEmpty && !cmplDone && !r_reg.mcPend && !rstEdge
        |=> r_reg.save_restore_pc == $past(idleRestartPc))
        else $error("idle interrupt saved wrong restart address");
    a_sync_fault_pc: assert property (
        r_reg.state == exs_pkg::EXS_WAIT && !olderBusy && storeQueueEmpty && !r_reg.mcPend
        && !rstEdge && !r_reg.trapFlag && !r_reg.excBits[`EXS_CAUSE_SYSCALL]
        |=> r_reg.save_restore_pc == $past(r_reg.faultPc))
        else $error("faulting address not saved");

    c_reset: cover property (rstEdge ##1 fetchRedirect);
    c_mcheck: cover property (r_reg.mcPend && !rstEdge ##1 fetchRedirect);
    c_sync: cover property (r_reg.state == exs_pkg::EXS_WAIT ##[1:20] fetchRedirect);
    c_async: cover property (r_reg.asyncRec && r_reg.state == exs_pkg::EXS_IDLE ##1 fetchRedirect);
    c_idle_done: cover property (r_reg.asyncRec && cmplDone && !execEmpty ##1 fetchRedirect);
endmodule

// >>> exs_sys_model.sv
// Behavioural model of the board logic driving reset, error and interrupt pins
`timescale 1ns/1ps
`include "exs_defs.svh"
module exs_sys_model (
    input  wire logic sys_clk,
    output logic      softResetIn,
    output logic      hardResetIn,
    output logic      transferErrorAck,
    output logic      machineCheckIn,
    output logic      extIrqIn,
    output logic      sysMgmtIrq
);
    initial begin
        softResetIn = 1'b0;
        hardResetIn = 1'b0;
        transferErrorAck = 1'b0;
        machineCheckIn = 1'b0;
        extIrqIn = 1'b0;
        sysMgmtIrq = 1'b0;
    end

    // Pins move just after an edge, as a clocked board controller would
    task automatic setPin(input int idx, input logic val);
        @(posedge sys_clk);
        case (idx)
            `EXS_PIN_SRST: softResetIn <= val;
            `EXS_PIN_HRST: hardResetIn <= val;
            `EXS_PIN_TEA: transferErrorAck <= val;
            `EXS_PIN_MCP: machineCheckIn <= val;
            `EXS_PIN_INT: extIrqIn <= val;
            default: sysMgmtIrq <= val;
        endcase
    endtask
endmodule

// >>> testbench.sv
// Self-checking testbench of the exception sequencer
`timescale 1ns/1ps
`include "exs_defs.svh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        softResetIn, hardResetIn, transferErrorAck, machineCheckIn, extIrqIn;
    logic        sysMgmtIrq, fetchRedirect, holdCompletion, problemState, extIrqEnable;
    logic        decrementerIrq = 1'b0, dataBusActive = 1'b0, addrParityErr = 1'b0;
    logic        dataParityErr = 1'b0, cmplValid = 1'b0, cmplDone = 1'b0, cmplExc = 1'b0;
    logic        cmplIsTrap = 1'b0, olderBusy = 1'b0, execEmpty = 1'b1, rfiExec = 1'b0;
    logic        storeQueueEmpty = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  cmplExcBits = 8'h00;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] cmplPc = 32'h0000_1000, cmplNextPc = 32'h0000_1004;
    logic [31:0] idleRestartPc = 32'h0000_2000, regWrData = 32'h0000_0000;
    logic [31:0] regRdData, fetchVector;
    int          errorCnt = 0;
    int          checked = 0;

    always #10 sys_clk = ~sys_clk;

    exs_sys_model pins (.sys_clk, .softResetIn, .hardResetIn, .transferErrorAck,
        .machineCheckIn, .extIrqIn, .sysMgmtIrq);
    exs_sequencer uut (.sys_clk, .sys_rst, .softResetIn, .hardResetIn, .transferErrorAck,
        .machineCheckIn, .extIrqIn, .sysMgmtIrq, .decrementerIrq, .dataBusActive,
        .addrParityErr, .dataParityErr, .cmplValid, .cmplDone, .cmplExc, .cmplExcBits,
        .cmplIsTrap, .cmplPc, .cmplNextPc, .olderBusy, .execEmpty, .idleRestartPc,
        .storeQueueEmpty, .rfiExec, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .fetchRedirect, .fetchVector, .holdCompletion, .problemState, .extIrqEnable);

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic checkReg(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 check(what, exp, regRdData);
    endtask

    // Bounded wait: a lost redirect must not hang the run
    task automatic waitRedirect(input logic [31:0] vec, input int limit);
        int n;
        n = 0;
        #1;
        while (fetchRedirect !== 1'b1 && n < limit) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check("redirect", 32'h1, {31'h0, fetchRedirect});
        check("vector", vec, fetchVector);
    endtask

    task automatic quiet(input int cycles);
        repeat (cycles) begin
            @(posedge sys_clk);
            #1 check("no redirect", 32'h0, {31'h0, fetchRedirect});
        end
    endtask

    task automatic pulseRfi();
        @(posedge sys_clk);
        rfiExec <= 1'b1;
        @(posedge sys_clk);
        rfiExec <= 1'b0;
    endtask

    task automatic raiseAsync(input int i, input logic v);
        if (i == 1) begin
            @(posedge sys_clk);
            decrementerIrq <= v;
        end else
            pins.setPin(i == 0 ? `EXS_PIN_INT : `EXS_PIN_SMI, v);
    endtask

    task automatic testReset();
        check("mode pins", 32'h0, {30'h0, problemState, extIrqEnable});
        checkReg("msr", `EXS_OFF_MSR, `EXS_MSR_RST);
        checkReg("unmapped", 4'h2, 32'h0);
        $display("test reset done");
    endtask

    task automatic testSync();
        @(posedge sys_clk);
        olderBusy <= 1'b1;
        cmplValid <= 1'b1;
        cmplExc <= 1'b1;
        cmplExcBits <= 8'h05;
        @(posedge sys_clk);
        cmplValid <= 1'b0;
        cmplExc <= 1'b0;
        cmplExcBits <= 8'h00;
        quiet(6);
        check("hold", 32'h1, {31'h0, holdCompletion});
        olderBusy <= 1'b0;
        waitRedirect(32'h0000_0300, 8);
        checkReg("save_restore_pc", `EXS_OFF_SAVE_RESTORE_PC, 32'h0000_1000);
        checkReg("msr", `EXS_OFF_MSR, 32'h0000_0002);
        checkReg("save_restore_status", `EXS_OFF_SAVE_RESTORE_STATUS, 32'h1800_0000);
        quiet(3);
        pulseRfi();
        waitRedirect(32'h0000_0600, 8);
        pulseRfi();
        quiet(4);
        $display("test sync done");
    endtask

    task automatic testAsync();
        logic [31:0] vec [3];
        vec = '{32'h0000_0500, 32'h0000_0900, 32'h0000_1400};
        for (int i = 0; i < 3; i++) begin
            regWrite(`EXS_OFF_MSR, 32'h0000_8000);
            check("ee on", 32'h1, {31'h0, extIrqEnable});
            storeQueueEmpty <= 1'b0;
            execEmpty <= (i != 2);
            raiseAsync(i, 1'b1);
            quiet(8);
            storeQueueEmpty <= 1'b1;
            if (i == 2) begin
                quiet(2);
                cmplDone <= 1'b1;
            end
            waitRedirect(vec[i], 6);
            cmplDone <= 1'b0;
            execEmpty <= 1'b1;
            checkReg("save_restore_pc", `EXS_OFF_SAVE_RESTORE_PC, i == 2 ? 32'h0000_1004 : 32'h0000_2000);
            check("ee off", 32'h0, {31'h0, extIrqEnable});
            raiseAsync(i, 1'b0);
            quiet(8);
            pulseRfi();
        end
        regWrite(`EXS_OFF_MSR, 32'h0000_0000);
        raiseAsync(0, 1'b1);
        quiet(20);
        raiseAsync(0, 1'b0);
        quiet(8);
        $display("test async done");
    endtask

    task automatic testMcheck();
        for (int i = 0; i < 4; i++) begin
            dataBusActive <= (i == 1);
            if (i < 2)
                pins.setPin(i == 0 ? `EXS_PIN_MCP : `EXS_PIN_TEA, 1'b1);
            @(posedge sys_clk);
            addrParityErr <= (i == 2);
            dataParityErr <= (i == 3);
            @(posedge sys_clk);
            addrParityErr <= 1'b0;
            dataParityErr <= 1'b0;
            waitRedirect(32'h0000_0200, 10);
            pins.setPin(`EXS_PIN_MCP, 1'b0);
            pins.setPin(`EXS_PIN_TEA, 1'b0);
            dataBusActive <= 1'b0;
            checkReg("msr", `EXS_OFF_MSR, 32'h0000_0000);
            repeat (8) @(posedge sys_clk);
        end
        $display("test machine check done");
    endtask

    task automatic testSysReset();
        // Reset while a fault waits on older work drops the fault
        pulseRfi();
        @(posedge sys_clk);
        olderBusy <= 1'b1;
        cmplValid <= 1'b1;
        cmplExc <= 1'b1;
        cmplExcBits <= 8'h01;
        @(posedge sys_clk);
        cmplValid <= 1'b0;
        cmplExc <= 1'b0;
        cmplExcBits <= 8'h00;
        pins.setPin(`EXS_PIN_HRST, 1'b1);
        waitRedirect(32'h0000_0100, 10);
        check("hold dropped", 32'h0, {31'h0, holdCompletion});
        olderBusy <= 1'b0;
        pins.setPin(`EXS_PIN_HRST, 1'b0);
        pulseRfi();
        quiet(8);
        for (int i = 0; i < 2; i++) begin
            pins.setPin(i, 1'b1);
            waitRedirect(32'h0000_0100, 10);
            pins.setPin(i, 1'b0);
            repeat (8) @(posedge sys_clk);
        end
        // Check already pending when the reset edge arrives
        pins.setPin(`EXS_PIN_MCP, 1'b1);
        pins.setPin(`EXS_PIN_SRST, 1'b1);
        waitRedirect(32'h0000_0100, 10);
        fork
            pins.setPin(`EXS_PIN_SRST, 1'b0);
            pins.setPin(`EXS_PIN_MCP, 1'b0);
        join
        repeat (8) @(posedge sys_clk);
        $display("test system reset done");
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        errorCnt++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        testReset();
        testSync();
        testAsync();
        testMcheck();
        testSysReset();
        conclude();
    end
endmodule
